/* rtl/mtr_pkg.sv */
// Package for the core memory access block: map, field layout, commands
// Assumes one instruction clock domain shared with the execution unit
package mtr_pkg;
   localparam int          DW            = 8;
   localparam int          PCW           = 12;
   localparam int          ROMW          = 15;
   localparam int          STACK_DEPTH   = 8;
   localparam int          SPW           = 3;
   localparam logic [7:0]  A_IND0        = 8'h00;
   localparam logic [7:0]  A_PTR0        = 8'h01;
   localparam logic [7:0]  A_IND1        = 8'h02;
   localparam logic [7:0]  A_PTR1        = 8'h03;
   localparam logic [7:0]  A_BANK        = 8'h04;
   localparam logic [7:0]  A_ACC         = 8'h05;
   localparam logic [7:0]  A_PCL         = 8'h06;
   localparam logic [7:0]  A_TABLE_POINTER        = 8'h07;
   localparam logic [7:0]  A_TABLE_HIGH_BYTE        = 8'h08;
   localparam logic [7:0]  A_STATUS      = 8'h0a;
   localparam logic [7:0]  A_GP_LO       = 8'h20;
   localparam logic [7:0]  A_GP_HI       = 8'hbf;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [11:0] VEC_RESET     = 12'h000;
   localparam logic [11:0] VEC_TMR1      = 12'h00c;
   localparam logic [3:0]  LAST_PAGE     = 4'hf;
   localparam logic [5:0]  STATUS_WMASK  = 6'h0f;
   localparam int          TABLE_HIGH_BYTE_BITS     = ROMW - DW;

   typedef enum logic [3:0] {
      MTR_OP_NONE = 4'h0, MTR_OP_ADD = 4'h1, MTR_OP_SUB = 4'h2, MTR_OP_AND = 4'h3,
      MTR_OP_OR = 4'h4, MTR_OP_XOR = 4'h5, MTR_OP_CPL = 4'h6, MTR_OP_RL = 4'h7,
      MTR_OP_RR = 4'h8, MTR_OP_RLC = 4'h9, MTR_OP_RRC = 4'ha, MTR_OP_INC = 4'hb,
      MTR_OP_DEC = 4'hc, MTR_OP_DAA = 4'hd, MTR_OP_MOV = 4'he
   } mtr_alu_op_t;

   // One instruction step from the execution unit
   typedef struct packed {
      logic        valid;
      mtr_alu_op_t op;
      logic        use_imm;
      logic        carry_in_op;
      logic        to_acc;
      logic [7:0]  addr;
      logic [7:0]  imm;
   } mtr_alu_req_t;

   typedef struct packed {
      logic        call;
      logic        ret;
      logic        return_from_interrupt;
      logic        tab_cur;
      logic        tab_last;
      logic [7:0]  tab_addr;
      logic [11:0] target;
   } mtr_flow_req_t;
endpackage

/* rtl/mtr_core_mem.sv */
// Table reads, return stack and banked data memory of the core
// Assumes the execution unit sends one request per cycle, same clock
`timescale 1ns/1ns
module mtr_core_mem import mtr_pkg::*; #(
   parameter int GP_WORDS = 160
) (
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire mtr_alu_req_t  alu_req,
   input  wire mtr_flow_req_t flow_req,
   input  wire logic [7:0]    bit_mask,
   input  wire logic          bit_set,
   input  wire logic          bit_clr,
   input  wire logic          tmr1_ovf,
   input  wire logic          tmr1_int_en,
   input  wire logic [14:0]   rom_data,
   input  wire logic [7:0]    bank1_rdata,
   output logic [11:0]        rom_addr,
   output logic [11:0]        pc,
   output logic               busy,
   output logic               skip,
   output logic [7:0]         rd_data,
   output logic               bank1_we,
   output logic [7:0]         bank1_addr,
   output logic [7:0]         bank1_wdata,
   output logic               tmr1_pending,
   output logic               stack_full
);
   typedef enum logic [1:0] {ST_RUN = 2'b01, ST_TAB = 2'b10} mtr_state_t;

   mtr_state_t       state_q;
   logic [7:0]       gp_mem [GP_WORDS];
   logic [7:0]       ptr0_q, ptr1_q, bank_q, acc_q, table_pointer_q, status_q;
   logic [TABLE_HIGH_BYTE_BITS-1:0] table_high_byte_q;
   logic [11:0]      stack_q [STACK_DEPTH];
   logic [SPW-1:0]   sp_q;
   logic [3:0]       depth_q;
   logic [11:0]      pc_q;
   logic [7:0]       tab_dst_q;
   logic             pend_q;
   logic             t1_s1_q, t1_s2_q, t1_s3_q;

   // Effective address and bank, shared by read and write paths
   function automatic logic [8:0] eff_addr(input logic [7:0] a);
      if (a == A_IND0) eff_addr = {1'b0, ptr0_q};
      else if (a == A_IND1) eff_addr = {bank_q == 8'h01, ptr1_q};
      else eff_addr = {1'b0, a};
   endfunction

   function automatic logic is_ind(input logic [7:0] a);
      is_ind = (a == A_IND0) || (a == A_IND1);
   endfunction

   function automatic logic [7:0] mem_rd(input logic [8:0] ea);
      logic [7:0] a;
      a = ea[7:0];
      if (ea[8]) mem_rd = ZERO_BYTE;
      else if (is_ind(a)) mem_rd = ZERO_BYTE;
      else if (a >= A_GP_LO && a <= A_GP_HI)
         mem_rd = gp_mem[a - A_GP_LO];
      else case (a)
         A_PTR0:   mem_rd = ptr0_q;
         A_PTR1:   mem_rd = ptr1_q;
         A_BANK:   mem_rd = bank_q;
         A_ACC:    mem_rd = acc_q;
         A_PCL:    mem_rd = pc_q[7:0];
         A_TABLE_POINTER:   mem_rd = table_pointer_q;
         A_TABLE_HIGH_BYTE:   mem_rd = {1'b0, table_high_byte_q};
         A_STATUS: mem_rd = status_q;
         default:  mem_rd = ZERO_BYTE;
      endcase
   endfunction

   logic [8:0]  ea;
   logic [7:0]  opnd, opa, res;
   logic        c_o, ac_o, ov_o, zflag, wr_res;
   logic [8:0]  sum;
   logic        irq_take, do_push, do_pop;

   assign ea = eff_addr(alu_req.addr);
   assign opnd = alu_req.use_imm ? alu_req.imm : mem_rd(ea);
   assign opa = acc_q;

   always_comb begin
      sum = 9'h000;
      res = opnd;
      c_o = status_q[0];
      ac_o = status_q[1];
      ov_o = status_q[3];
      wr_res = alu_req.valid && state_q == ST_RUN;
      case (alu_req.op)
         MTR_OP_ADD: begin
            sum = {1'b0, opa} + {1'b0, opnd} + {8'h00, alu_req.carry_in_op & status_q[0]};
            res = sum[7:0];
            c_o = sum[8];
            ac_o = ({1'b0, opa[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
            ov_o = (opa[7] == opnd[7]) && (res[7] != opa[7]);
         end
         MTR_OP_SUB: begin
            sum = {1'b0, opa} - {1'b0, opnd};
            res = sum[7:0];
            c_o = ~sum[8];
            ac_o = opa[3:0] >= opnd[3:0];
            ov_o = (opa[7] != opnd[7]) && (res[7] != opa[7]);
         end
         MTR_OP_AND: res = opa & opnd;
         MTR_OP_OR:  res = opa | opnd;
         MTR_OP_XOR: res = opa ^ opnd;
         MTR_OP_CPL: res = ~opnd;
         MTR_OP_RL:  res = {opnd[6:0], opnd[7]};
         MTR_OP_RR:  res = {opnd[0], opnd[7:1]};
         MTR_OP_RLC: begin
            res = {opnd[6:0], status_q[0]};
            c_o = opnd[7];
         end
         MTR_OP_RRC: begin
            res = {status_q[0], opnd[7:1]};
            c_o = opnd[0];
         end
         MTR_OP_INC: res = opnd + 8'h01;
         MTR_OP_DEC: res = opnd - 8'h01;
         MTR_OP_DAA: begin
            res = opa;
            if (opa[3:0] > 4'h9 || status_q[1]) res = res + 8'h06;
            if (res[7:4] > 4'h9 || status_q[0]) begin
               res = res + 8'h60;
               c_o = 1'b1;
            end
         end
         MTR_OP_MOV: res = (alu_req.to_acc || alu_req.use_imm) ? opnd : opa;
         default: wr_res = wr_res && (bit_set || bit_clr);
      endcase
      if (bit_set) res = opnd | bit_mask;
      if (bit_clr) res = opnd & ~bit_mask;
      zflag = (res == ZERO_BYTE);
   end

   logic [7:0] wa;
   logic       wr_mem;
   assign wr_mem = wr_res && !alu_req.to_acc && !alu_req.use_imm && !ea[8]
                   && !is_ind(ea[7:0]);
   assign wa = ea[7:0];

   // Two-stage sync for timer overflow, edge on synced copies only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         t1_s1_q <= 1'b0;
         t1_s2_q <= 1'b0;
         t1_s3_q <= 1'b0;
      end else begin
         t1_s1_q <= tmr1_ovf;
         t1_s2_q <= t1_s1_q;
         t1_s3_q <= t1_s2_q;
      end
   end

   // Pending flag kept while stack is full; new overflow beats the clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) pend_q <= 1'b0;
      else if (t1_s2_q && !t1_s3_q) pend_q <= 1'b1;
      else if (irq_take) pend_q <= 1'b0;
   end

   // A return in the same cycle goes first, or its pop would be lost
   assign irq_take = pend_q && tmr1_int_en && state_q == ST_RUN
                     && depth_q != 4'(STACK_DEPTH) && !flow_req.call
                     && !flow_req.ret && !flow_req.return_from_interrupt;
   assign do_push = state_q == ST_RUN && (flow_req.call || irq_take);
   assign do_pop  = state_q == ST_RUN && (flow_req.ret || flow_req.return_from_interrupt) && !do_push;

   // Circular stack; overflow overwrites oldest without other effect
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sp_q <= '0;
         depth_q <= 4'h0;
      end else if (do_push) begin
         sp_q <= sp_q + 3'(1);
         if (depth_q != 4'(STACK_DEPTH)) depth_q <= depth_q + 4'h1;
      end else if (do_pop) begin
         sp_q <= sp_q - 3'(1);
         if (depth_q != 4'h0) depth_q <= depth_q - 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (do_push) stack_q[sp_q] <= pc_q;
   end

   // Program counter
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) pc_q <= VEC_RESET;
      else if (irq_take) pc_q <= VEC_TMR1;
      else if (do_push) pc_q <= flow_req.target;
      else if (do_pop) pc_q <= stack_q[sp_q - 3'(1)];
      else if (wr_mem && wa == A_PCL) pc_q <= {pc_q[11:8], res};
      else if (state_q == ST_RUN) pc_q <= pc_q + 12'h001;
   end

   // Table lookup sequencer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_RUN;
         tab_dst_q <= ZERO_BYTE;
         rom_addr <= VEC_RESET;
      end else case (state_q)
         ST_RUN: begin
            rom_addr <= pc_q;
            if (flow_req.tab_cur || flow_req.tab_last) begin
               state_q <= ST_TAB;
               tab_dst_q <= flow_req.tab_addr;
               rom_addr <= {flow_req.tab_last ? LAST_PAGE : pc_q[11:8], table_pointer_q};
            end
         end
         ST_TAB: state_q <= ST_RUN;
         default: state_q <= ST_RUN;
      endcase
   end

   logic [8:0] tea;
   logic       tab_wr;
   assign tea = eff_addr(tab_dst_q);
   assign tab_wr = state_q == ST_TAB && !tea[8] && !is_ind(tea[7:0]);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) table_high_byte_q <= '0;
      else if (state_q == ST_TAB) table_high_byte_q <= rom_data[ROMW-1:DW];
   end

   // Special registers; table_high_byte has no write path
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ptr0_q <= ZERO_BYTE;
         ptr1_q <= ZERO_BYTE;
         bank_q <= ZERO_BYTE;
         acc_q <= ZERO_BYTE;
         table_pointer_q <= ZERO_BYTE;
         status_q <= ZERO_BYTE;
      end else begin
         if (wr_res && (alu_req.to_acc || alu_req.use_imm)) acc_q <= res;
         if (wr_res && !bit_set && !bit_clr)
            status_q[3:0] <= {ov_o, zflag, ac_o, c_o};
         if (wr_mem) case (wa)
            A_PTR0:   ptr0_q <= res;
            A_PTR1:   ptr1_q <= res;
            A_BANK:   bank_q <= res;
            A_ACC:    acc_q <= res;
            A_TABLE_POINTER:   table_pointer_q <= res;
            A_STATUS: status_q <= {2'b00, res[5:0] & STATUS_WMASK};
            default:  ;
         endcase
         if (tab_wr && tea[7:0] == A_ACC) acc_q <= rom_data[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (tab_wr && tea[7:0] >= A_GP_LO && tea[7:0] <= A_GP_HI)
         gp_mem[tea[7:0] - A_GP_LO] <= rom_data[7:0];
      else if (wr_mem && wa >= A_GP_LO && wa <= A_GP_HI)
         gp_mem[wa - A_GP_LO] <= res;
   end

   // Registered outputs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc <= VEC_RESET;
         busy <= 1'b0;
         skip <= 1'b0;
         rd_data <= ZERO_BYTE;
         bank1_we <= 1'b0;
         bank1_addr <= ZERO_BYTE;
         bank1_wdata <= ZERO_BYTE;
         tmr1_pending <= 1'b0;
         stack_full <= 1'b0;
      end else begin
         pc <= pc_q;
         busy <= state_q == ST_RUN && (flow_req.tab_cur || flow_req.tab_last);
         skip <= wr_res && zflag;
         rd_data <= ea[8] ? bank1_rdata : opnd;
         bank1_we <= wr_res && ea[8] && !alu_req.to_acc;
         // Only pointer 1 reaches bank 1; lags a pointer write by one cycle
         bank1_addr <= ptr1_q;
         bank1_wdata <= res;
         tmr1_pending <= pend_q;
         stack_full <= depth_q == 4'(STACK_DEPTH);
      end
   end

   // Lookup steps: request in a run cycle, one table cycle, back to run
   sequence s_tab_req;
      state_q == ST_RUN && (flow_req.tab_cur || flow_req.tab_last);
   endsequence
   sequence s_tab_done;
      state_q == ST_TAB ##1 state_q == ST_RUN;
   endsequence

   AST_TAB_TWO_CYC: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == ST_TAB |=> state_q == ST_RUN) else $error("table step too long");
   AST_TAB_SEQ: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_tab_req |=> s_tab_done) else $error("table sequence broken");
   AST_VEC: assert property (@(posedge ref_clk) disable iff (!nrst)
      irq_take |=> pc_q == VEC_TMR1) else $error("bad vector");
   AST_FULL_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
      depth_q == 4'(STACK_DEPTH) |-> !irq_take) else $error("irq on full stack");
   AST_DEPTH_MAX: assert property (@(posedge ref_clk) disable iff (!nrst)
      depth_q <= 4'(STACK_DEPTH)) else $error("depth over");
   AST_OVF_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
      depth_q == 4'(STACK_DEPTH) && do_push |=> depth_q == 4'(STACK_DEPTH))
      else $error("overflow changed depth");
   AST_PUSH_IDX: assert property (@(posedge ref_clk) disable iff (!nrst)
      do_push |=> sp_q == $past(sp_q) + 3'(1)) else $error("stack index step");
   AST_TABLE_HIGH_BYTE_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q == ST_TAB |=> table_high_byte_q == $past(rom_data[14:8])) else $error("table_high_byte");
   AST_TABLE_HIGH_BYTE_RO: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_q != ST_TAB |=> $stable(table_high_byte_q)) else $error("table_high_byte written");
   AST_POP: assert property (@(posedge ref_clk) disable iff (!nrst)
      do_push ##1 do_pop |=> pc_q == $past(pc_q, 2)) else $error("pop mismatch");
   AST_PTR0_BANK0: assert property (@(posedge ref_clk) disable iff (!nrst)
      alu_req.addr == A_IND0 |-> !ea[8]) else $error("pointer 0 left bank 0");
   AST_IND_RD: assert property (@(posedge ref_clk) disable iff (!nrst)
      alu_req.addr == A_IND0 && ptr0_q == A_IND0 |-> mem_rd(ea) == ZERO_BYTE)
      else $error("indirect self read");
endmodule

/* testbench/mtr_far_model.sv */
// Far-side model: program ROM and bank 1 register file
// Assumes combinational ROM reads and bank 1 writes on the clock edge
`timescale 1ns/1ns
module mtr_far_model import mtr_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic [11:0] rom_addr,
   output logic [14:0]      rom_data,
   input  wire logic        bank1_we,
   input  wire logic [7:0]  bank1_addr,
   input  wire logic [7:0]  bank1_wdata,
   output logic [7:0]       bank1_rdata
);
   logic [7:0] mem [256];

   // Page bits feed the word so a wrong page shows
   assign rom_data = {rom_addr[11:5] ^ 7'h2b, rom_addr[7:0] ^ 8'hc6};
   assign bank1_rdata = mem[bank1_addr];

   always_ff @(posedge ref_clk) begin
      if (bank1_we) begin
         mem[bank1_addr] <= bank1_wdata;
      end
   end
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the core memory access block
// Assumes the far-side model for ROM and bank 1, one clock
`timescale 1ns/1ns
module testbench import mtr_pkg::*; ;
   logic          ref_clk;
   logic          nrst;
   mtr_alu_req_t  alu_req;
   mtr_flow_req_t flow_req;
   logic [7:0]    bit_mask;
   logic          bit_set;
   logic          bit_clr;
   logic          tmr1_ovf;
   logic          tmr1_int_en;
   logic [14:0]   rom_data;
   logic [7:0]    bank1_rdata;
   logic [11:0]   rom_addr;
   logic [11:0]   pc;
   logic          busy;
   logic          skip;
   logic [7:0]    rd_data;
   logic          bank1_we;
   logic [7:0]    bank1_addr;
   logic [7:0]    bank1_wdata;
   logic          tmr1_pending;
   logic          stack_full;
   logic [14:0]   w;
   int            bad_count;
   int            checked;
   int            n;

   mtr_core_mem uut (.ref_clk(ref_clk), .nrst(nrst), .alu_req(alu_req), .flow_req(flow_req),
      .bit_mask(bit_mask), .bit_set(bit_set), .bit_clr(bit_clr), .tmr1_ovf(tmr1_ovf),
      .tmr1_int_en(tmr1_int_en), .rom_data(rom_data), .bank1_rdata(bank1_rdata),
      .rom_addr(rom_addr), .pc(pc), .busy(busy), .skip(skip), .rd_data(rd_data),
      .bank1_we(bank1_we), .bank1_addr(bank1_addr), .bank1_wdata(bank1_wdata),
      .tmr1_pending(tmr1_pending), .stack_full(stack_full));

   mtr_far_model far (.ref_clk(ref_clk), .rom_addr(rom_addr), .rom_data(rom_data),
      .bank1_we(bank1_we), .bank1_addr(bank1_addr), .bank1_wdata(bank1_wdata),
      .bank1_rdata(bank1_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [14:0] rw(input logic [11:0] a);
      return {a[11:5] ^ 7'h2b, a[7:0] ^ 8'hc6};
   endfunction

   function automatic mtr_flow_req_t mk(input logic c, r, tc, tl, input logic [7:0] a,
                                        input logic [11:0] t);
      return '{c, r, 1'b0, tc, tl, a, t};
   endfunction

   task automatic print_verdict();
      $display("Checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rst();
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      #1;
   endtask

   // One instruction, then an idle cycle before the next
   task automatic step(input mtr_alu_op_t op, input logic im, ta, input logic [7:0] a, d);
      @(posedge ref_clk);
      alu_req <= '{1'b1, op, im, 1'b0, ta, a, d};
      @(posedge ref_clk);
      alu_req <= '0;
      #1;
   endtask

   task automatic bop(input logic [7:0] a, m, input logic s);
      @(posedge ref_clk);
      alu_req <= '{1'b1, MTR_OP_NONE, 1'b0, 1'b0, 1'b0, a, 8'h00};
      bit_mask <= m;
      bit_set <= s;
      bit_clr <= !s;
      @(posedge ref_clk);
      alu_req <= '0;
      bit_set <= 1'b0;
      bit_clr <= 1'b0;
      #1;
   endtask

   task automatic fl(input mtr_flow_req_t f);
      @(posedge ref_clk);
      flow_req <= f;
      @(posedge ref_clk);
      flow_req <= '0;
      #1;
   endtask

   // Moves go through the accumulator
   task automatic wr(input logic [7:0] a, d);
      step(MTR_OP_MOV, 1'b1, 1'b1, 8'h00, d);
      step(MTR_OP_MOV, 1'b0, 1'b0, a, 8'h00);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, exp);
      step(MTR_OP_MOV, 1'b0, 1'b1, a, 8'h00);
      chk(nm, rd_data, exp);
   endtask

   initial begin
      nrst = 1'b0;
      alu_req = '0;
      flow_req = '0;
      bit_mask = 8'h00;
      bit_set = 1'b0;
      bit_clr = 1'b0;
      tmr1_ovf = 1'b0;
      tmr1_int_en = 1'b0;
      bad_count = 0;
      checked = 0;
      rst();
      chk("stack_full", stack_full, 1'b0);
      wr(A_TABLE_POINTER, 8'h34);
      rd("table_pointer", A_TABLE_POINTER, 8'h34);
      fl(mk(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 12'h512));
      for (int i = 0; i < 2; i++) begin
         w = rw({i ? 4'hf : 4'h5, 8'h34});
         fl(mk(1'b0, 1'b0, i == 0, i == 1, 8'h40, 12'h000));
         chk("table_busy", busy, 1'b1);
         chk("table_addr", rom_addr, {i ? 4'hf : 4'h5, 8'h34});
         @(posedge ref_clk);
         #1;
         chk("table_done", busy, 1'b0);
         rd("table_low", 8'h40, w[7:0]);
         wr(A_TABLE_HIGH_BYTE, 8'hff);
         rd("table_high", A_TABLE_HIGH_BYTE, {1'b0, w[14:8]});
      end
      wr(A_PTR0, 8'h21);
      wr(A_IND0, 8'h77);
      rd("via_ptr0", 8'h21, 8'h77);
      rd("ptr0", A_PTR0, 8'h21);
      wr(A_PTR0, 8'h00);
      rd("self_read0", A_IND0, 8'h00);
      wr(A_PTR1, 8'h02);
      wr(A_IND1, 8'h55);
      rd("self_read", A_IND1, 8'h00);
      rd("ptr1", A_PTR1, 8'h02);
      wr(A_BANK, 8'h01);
      wr(A_PTR1, 8'h42);
      wr(A_IND1, 8'h3c);
      rd("bank1", A_IND1, 8'h3c);
      chk("bank1_mem", far.mem[8'h42], 8'h3c);
      wr(A_PTR0, 8'h22);
      wr(A_IND0, 8'h11);
      rd("ptr0_bank0", 8'h22, 8'h11);
      wr(A_BANK, 8'h00);
      rd("unassigned", 8'h1f, 8'h00);
      wr(A_GP_LO, 8'ha5);
      wr(A_GP_HI, 8'h5a);
      rd("gp_low", A_GP_LO, 8'ha5);
      rd("gp_high", A_GP_HI, 8'h5a);
      wr(8'h23, 8'h05);
      step(MTR_OP_MOV, 1'b1, 1'b1, 8'h00, 8'h03);
      step(MTR_OP_ADD, 1'b0, 1'b0, 8'h23, 8'h00);
      rd("add", 8'h23, 8'h08);
      step(MTR_OP_SUB, 1'b0, 1'b0, 8'h23, 8'h00);
      chk("skip", skip, 1'b1);
      step(MTR_OP_ADD, 1'b1, 1'b1, 8'h00, 8'h10);
      rd("acc_imm", A_ACC, 8'h18);
      bop(8'h23, 8'h81, 1'b1);
      bop(8'h23, 8'h01, 1'b0);
      rd("bit_ops", 8'h23, 8'h80);
      // Call k lands on page k+1, so each pop names its push
      rst();
      for (int k = 0; k < 9; k++) begin
         fl(mk(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, {k[3:0] + 4'h1, 8'h10}));
         if (k == 7) begin
            @(posedge ref_clk);
            #1;
            chk("full", stack_full, 1'b1);
         end
      end
      for (int i = 1; i <= 8; i++) begin
         fl(mk(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h000));
         @(posedge ref_clk);
         #1;
         chk("pop_page", pc[11:8], 9 - i);
      end
      // Call and return on back-to-back cycles
      @(posedge ref_clk);
      flow_req <= mk(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 12'h312);
      @(posedge ref_clk);
      flow_req <= mk(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h000);
      @(posedge ref_clk);
      flow_req <= '0;
      @(posedge ref_clk);
      #1;
      chk("call_ret_page", pc[11:8], 4'h1);
      rst();
      tmr1_int_en <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         fl(mk(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, {k[3:0] + 4'h1, 8'h10}));
      end
      tmr1_ovf <= 1'b1;
      repeat (3) @(posedge ref_clk);
      tmr1_ovf <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("held_flag", tmr1_pending, 1'b1);
      chk("held_page", pc[11:8], 4'h8);
      fl(mk(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h000));
      n = 0;
      while (pc !== VEC_TMR1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("vector", pc, VEC_TMR1);
      if (n == 20) print_verdict();
      fl(mtr_flow_req_t'{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h000});
      @(posedge ref_clk);
      #1;
      chk("return_from_interrupt_page", pc[11:8], 4'h7);
      print_verdict();
   end
endmodule
